// ---- core/slsup_pkg.sv ----
// package of constants and types for the signal limit supervisor
package slsup_pkg;
	localparam int          DW          = 32;
	localparam int          TW          = 34;
	// register byte offsets
	localparam logic [7:0]  OFS_CTRL    = 8'h00;
	localparam logic [7:0]  OFS_LOW     = 8'h04;
	localparam logic [7:0]  OFS_HIGH    = 8'h08;
	localparam logic [7:0]  OFS_HYST    = 8'h0C;
	localparam logic [7:0]  OFS_STATUS  = 8'h10;
	localparam logic [7:0]  OFS_IRQ_ST  = 8'h14;
	localparam logic [7:0]  OFS_IRQ_MSK = 8'h18;
	localparam logic [7:0]  OFS_EVCODE  = 8'h1C;
	// field positions
	localparam int          CTRL_MODE_LSB = 0;
	localparam int          CTRL_ACT_LSB  = 8;
	localparam int          ST_COND_BIT   = 0;
	localparam int          ST_WARN_BIT   = 1;
	localparam int          ST_FAULT_BIT  = 2;
	localparam int          IRQ_WARN_BIT  = 0;
	localparam int          IRQ_FAULT_BIT = 1;
	// mode codes
	localparam logic [3:0]  MODE_OFF    = 4'h0;
	localparam logic [3:0]  MODE_BOTH   = 4'h5;
	localparam logic [3:0]  MODE_ABSB   = 4'h6;
	localparam logic [3:0]  MODE_HYST   = 4'h7;
	localparam logic [3:0]  MODE_LOWF   = 4'h8;
	localparam logic [3:0]  MODE_HIGHR  = 4'h9;
	// action codes
	localparam logic [1:0]  ACT_NONE    = 2'h0;
	localparam logic [1:0]  ACT_WARN    = 2'h1;
	localparam logic [1:0]  ACT_FAULT   = 2'h2;
	// event codes
	localparam logic [15:0] CODE_WARN   = 16'hA8B1;
	localparam logic [15:0] CODE_FAULT  = 16'h80B1;
	// value ranges in hundredths
	localparam logic signed [31:0] HYST_MAX  = 32'sh00989680;
	localparam logic signed [31:0] LIM_MAX   = 32'sh7FFFFFD0;
	localparam logic signed [31:0] LIM_MIN   = -32'sh7FFFFFD0;
	// reset values
	localparam logic [3:0]  RST_MODE    = 4'h0;
	localparam logic [1:0]  RST_ACT     = 2'h0;
	localparam logic signed [31:0] RST_LIM = 32'sh00000000;

	typedef struct packed {
		logic signed [TW-1:0] hi_p;
		logic signed [TW-1:0] hi_m;
		logic signed [TW-1:0] lo_p;
		logic signed [TW-1:0] lo_m;
	} slsup_thr_t;

	typedef struct packed {
		logic [3:0]           mode;
		logic [1:0]           action;
		logic signed [DW-1:0] low;
		logic signed [DW-1:0] high;
		logic signed [DW-1:0] hyst;
		logic                 cond;
		logic signed [DW-1:0] prev;
		logic                 prev_ok;
		logic                 fault;
		logic                 warn;
		logic [1:0]           irq_stat;
		logic [1:0]           irq_mask;
		logic [15:0]          evcode;
		logic [31:0]          prdata;
		logic                 pready;
		logic                 pslverr;
		logic                 irq;
	} slsup_state_t;
endpackage

// ---- core/slsup_thresh.sv ----
// threshold builder: limits plus or minus half hysteresis
`timescale 1ns/1ns
`default_nettype none
module slsup_thresh (
	input  wire logic signed [31:0] low,
	input  wire logic signed [31:0] high,
	input  wire logic signed [31:0] hyst,
	output slsup_pkg::slsup_thr_t   thr
);
	logic signed [33:0] half;
	logic signed [33:0] lo_x;
	logic signed [33:0] hi_x;

	always_comb begin
		half     = 34'(hyst >>> 1);
		lo_x     = 34'(low);
		hi_x     = 34'(high);
		thr.hi_p = hi_x + half;
		thr.hi_m = hi_x - half;
		thr.lo_p = lo_x + half;
		thr.lo_m = lo_x - half;
	end
endmodule // slsup_thresh
`default_nettype wire

// ---- core/slsup_top.sv ----
// signal limit supervisor channel with apb registers
//
// Function
// - mode 5 sets above high+h/2 or below low-h/2 and clears between high-h/2 and low+h/2.
// - mode 6 is the same band test on magnitudes of signal and thresholds.
// - mode 7 sets above high+h/2, clears below low-h/2 and holds in between.
// - mode 8 sets only on a fall from above low+h/2 to below low-h/2.
// - mode 8 clears an active condition once the signal rises above low+h/2.
// - mode 9 sets only on a rise from below high-h/2 to above high+h/2.
// - mode 9 clears an active condition once the signal falls below high-h/2.
// - action code 0 does nothing, 1 warns, 2 faults, and no action after reset.
// - with warning action a warning stands while the condition is active, with code A8B1 unless a fault is latched.
// - with fault action the block trips and reports code 80B1 when the condition rises.
// - the action never alters the status flag.
// - mode 0 disables the channel so no condition is ever reported.
// - hysteresis is held in 0..100000.00 and limits in +/-21474836.00.
`timescale 1ns/1ns
`default_nettype none
module slsup_top (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sample_tick,
	input  wire logic [31:0] sig_in,
	output logic             cond_out,
	output logic             warn_out,
	output logic             fault_out,
	output logic [15:0]      event_code,
	output logic             irq
);
	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// one bit of headroom so the most negative value cannot wrap
	function automatic logic signed [33:0] abs34(input logic signed [33:0] v);
		abs34 = v[33] ? -v : v;
	endfunction

	// settings out of range are clamped rather than refused
	function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
		input logic signed [31:0] lo, input logic signed [31:0] hi);
		if (v < lo) begin
			clamp = lo;
		end else if (v > hi) begin
			clamp = hi;
		end else begin
			clamp = v;
		end
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		case (a)
			slsup_pkg::OFS_CTRL, slsup_pkg::OFS_LOW, slsup_pkg::OFS_HIGH,
			slsup_pkg::OFS_HYST, slsup_pkg::OFS_STATUS, slsup_pkg::OFS_IRQ_ST,
			slsup_pkg::OFS_IRQ_MSK, slsup_pkg::OFS_EVCODE: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// thresholds

	slsup_pkg::slsup_state_t st_reg;
	slsup_pkg::slsup_state_t st_next;
	slsup_pkg::slsup_thr_t   thr;

	slsup_thresh u_thresh (
		.low  (st_reg.low),
		.high (st_reg.high),
		.hyst (st_reg.hyst),
		.thr  (thr)
	);

	////////////////////////////////////////////////////////////////////////////////
	// threshold crossings of the present and the kept sample

	logic signed [33:0] s;
	logic signed [33:0] p;
	logic signed [33:0] sa;
	logic               s_over_hp;
	logic               s_under_hm;
	logic               s_over_lp;
	logic               s_under_lm;
	logic               p_over_lp;
	logic               p_under_hm;
	logic               a_over_hp;
	logic               a_under_hm;
	logic               a_over_lp;
	logic               a_under_lm;

	assign s          = 34'(signed'(sig_in));
	assign p          = 34'(st_reg.prev);
	assign sa         = abs34(s);

	assign s_over_hp  = s > thr.hi_p;
	assign s_under_hm = s < thr.hi_m;
	assign s_over_lp  = s > thr.lo_p;
	assign s_under_lm = s < thr.lo_m;
	assign p_over_lp  = p > thr.lo_p;
	assign p_under_hm = p < thr.hi_m;

	// magnitudes for the absolute band
	assign a_over_hp  = sa > abs34(thr.hi_p);
	assign a_under_hm = sa < abs34(thr.hi_m);
	assign a_over_lp  = sa > abs34(thr.lo_p);
	assign a_under_lm = sa < abs34(thr.lo_m);

	////////////////////////////////////////////////////////////////////////////////
	// next state

	logic               cnd;
	logic               wr;
	logic               rd_setup;
	logic               mode_chg;
	logic [3:0]         wmode;
	logic               warn_ev;
	logic               fault_ev;
	logic [1:0]         w1c;
	logic [31:0]        rdv;

	always_comb begin
		st_next  = st_reg;
		cnd      = st_reg.cond;
		warn_ev  = 1'b0;
		fault_ev = 1'b0;
		w1c      = 2'h0;
		rdv      = 32'h00000000;
		wr       = psel && penable && st_reg.pready && pwrite;
		rd_setup = psel && !penable;
		// a write that changes the mode restarts evaluation from an idle condition
		wmode    = pwdata[slsup_pkg::CTRL_MODE_LSB +: 4];
		mode_chg = wr && paddr == slsup_pkg::OFS_CTRL && wmode != st_reg.mode;

		// comparison on each sample tick
		if (sample_tick) begin
			case (st_reg.mode)
				slsup_pkg::MODE_BOTH: begin
					if (s_over_hp || s_under_lm) begin
						cnd = 1'b1;
					end else if (s_under_hm && s_over_lp) begin
						cnd = 1'b0;
					end
				end
				slsup_pkg::MODE_ABSB: begin
					if (a_over_hp || a_under_lm) begin
						cnd = 1'b1;
					end else if (a_under_hm && a_over_lp) begin
						cnd = 1'b0;
					end
				end
				slsup_pkg::MODE_HYST: begin
					if (s_over_hp) begin
						cnd = 1'b1;
					end else if (s_under_lm) begin
						cnd = 1'b0;
					end
				end
				slsup_pkg::MODE_LOWF: begin
					if (!st_reg.cond) begin
						cnd = st_reg.prev_ok && p_over_lp && s_under_lm;
					end else if (s_over_lp) begin
						cnd = 1'b0;
					end
				end
				slsup_pkg::MODE_HIGHR: begin
					if (!st_reg.cond) begin
						cnd = st_reg.prev_ok && p_under_hm && s_over_hp;
					end else if (s_under_hm) begin
						cnd = 1'b0;
					end
				end
				default: cnd = 1'b0;
			endcase
			// kept sample for the crossing modes
			st_next.prev    = signed'(sig_in);
			st_next.prev_ok = 1'b1;
		end

		// action selection, status flag unaffected
		st_next.cond = cnd;
		if (cnd && !st_reg.cond && !mode_chg) begin
			warn_ev  = st_reg.action == slsup_pkg::ACT_WARN;
			fault_ev = st_reg.action == slsup_pkg::ACT_FAULT;
		end

		// register writes
		if (wr) begin
			case (paddr)
				slsup_pkg::OFS_CTRL: begin
					st_next.mode   = wmode;
					st_next.action = pwdata[slsup_pkg::CTRL_ACT_LSB +: 2];
					if (mode_chg) begin
						st_next.cond = 1'b0;
					end
				end
				slsup_pkg::OFS_LOW:
					st_next.low  = clamp(pwdata, slsup_pkg::LIM_MIN, slsup_pkg::LIM_MAX);
				slsup_pkg::OFS_HIGH:
					st_next.high = clamp(pwdata, slsup_pkg::LIM_MIN, slsup_pkg::LIM_MAX);
				slsup_pkg::OFS_HYST:
					st_next.hyst = clamp(pwdata, 32'sh00000000, slsup_pkg::HYST_MAX);
				slsup_pkg::OFS_STATUS:
					if (pwdata[slsup_pkg::ST_FAULT_BIT]) begin
						st_next.fault = 1'b0;
					end
				slsup_pkg::OFS_IRQ_ST:
					w1c = pwdata[1:0];
				slsup_pkg::OFS_IRQ_MSK:
					st_next.irq_mask = pwdata[1:0];
				default: ;
			endcase
		end

		// warning level follows the condition under the action now in force
		st_next.warn = st_next.cond && st_next.action == slsup_pkg::ACT_WARN;

		// fault latch, trip wins over a clear
		if (fault_ev) begin
			st_next.fault = 1'b1;
		end

		// sticky interrupt status, set wins over clear
		st_next.irq_stat = (st_reg.irq_stat & ~w1c) | {fault_ev, warn_ev};
		// irq is a flop of the masked status, so it never glitches
		st_next.irq      = |(st_next.irq_stat & st_next.irq_mask);

		if (st_next.fault) begin
			st_next.evcode = slsup_pkg::CODE_FAULT;
		end else if (st_next.warn) begin
			st_next.evcode = slsup_pkg::CODE_WARN;
		end else begin
			st_next.evcode = 16'h0000;
		end

		// apb: answer prepared in the setup cycle, no wait state
		case (paddr)
			slsup_pkg::OFS_CTRL: begin
				rdv[slsup_pkg::CTRL_MODE_LSB +: 4] = st_reg.mode;
				rdv[slsup_pkg::CTRL_ACT_LSB +: 2]  = st_reg.action;
			end
			slsup_pkg::OFS_LOW:     rdv = st_reg.low;
			slsup_pkg::OFS_HIGH:    rdv = st_reg.high;
			slsup_pkg::OFS_HYST:    rdv = st_reg.hyst;
			slsup_pkg::OFS_STATUS: begin
				rdv[slsup_pkg::ST_COND_BIT]  = st_reg.cond;
				rdv[slsup_pkg::ST_WARN_BIT]  = st_reg.warn;
				rdv[slsup_pkg::ST_FAULT_BIT] = st_reg.fault;
			end
			slsup_pkg::OFS_IRQ_ST:  rdv[1:0]  = st_reg.irq_stat;
			slsup_pkg::OFS_IRQ_MSK: rdv[1:0]  = st_reg.irq_mask;
			slsup_pkg::OFS_EVCODE:  rdv[15:0] = st_reg.evcode;
			default: ;
		endcase
		// the answer for a read is taken from the state at the setup edge
		if (rd_setup) begin
			st_next.pready  = 1'b1;
			// unknown offsets answer with an error and zero data
			st_next.pslverr = !mapped(paddr);
			st_next.prdata  = pwrite ? 32'h00000000 : rdv;
		end else begin
			st_next.pready  = 1'b0;
			st_next.pslverr = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	// reset leaves the channel disabled with no action selected
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg          <= '0;
			st_reg.mode     <= slsup_pkg::RST_MODE;
			st_reg.action   <= slsup_pkg::RST_ACT;
			st_reg.low      <= slsup_pkg::RST_LIM;
			st_reg.high     <= slsup_pkg::RST_LIM;
		end else begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign prdata     = st_reg.prdata;
	assign pready     = st_reg.pready;
	assign pslverr    = st_reg.pslverr;
	assign cond_out   = st_reg.cond;
	assign warn_out   = st_reg.warn;
	assign fault_out  = st_reg.fault;
	assign event_code = st_reg.evcode;
	assign irq        = st_reg.irq;
endmodule // slsup_top
`default_nettype wire

// ---- verification/slsup_properties.sv ----
// port relation checker of the supervisor channel
`timescale 1ns/1ns
`default_nettype none
module slsup_properties (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic        sample_tick,
	input wire logic        cond_out,
	input wire logic        warn_out,
	input wire logic        fault_out,
	input wire logic [15:0] event_code
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	property p_warn_code; warn_out && !fault_out |-> event_code == 16'hA8B1; endproperty
	a_warn_code: assert property (p_warn_code) else $error("warning code wrong");
	property p_fault_code; fault_out |-> event_code == 16'h80B1; endproperty
	a_fault_code: assert property (p_fault_code) else $error("fault code wrong");
	property p_idle_code; !fault_out && !warn_out |-> event_code == 16'h0000; endproperty
	a_idle_code: assert property (p_idle_code) else $error("code without event");
	property p_warn_cond; warn_out |-> cond_out; endproperty
	a_warn_cond: assert property (p_warn_cond) else $error("warning without condition");
	property p_trip; $rose(fault_out) |-> $rose(cond_out); endproperty
	a_trip: assert property (p_trip) else $error("trip without condition onset");
	property p_cond_cause;
		$changed(cond_out) |-> $past(sample_tick) || $past(psel && penable && pwrite) || $past(rst);
	endproperty
	a_cond_cause: assert property (p_cond_cause) else $error("status moved without tick");
	property p_fault_hold; fault_out && !(psel && penable && pwrite) |=> fault_out; endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault latch lost");
	property p_warn_tick; $rose(warn_out) |-> $past(sample_tick) || $past(psel && pwrite); endproperty
	a_warn_tick: assert property (p_warn_tick) else $error("warning without tick");
endmodule // slsup_properties
`default_nettype wire

// ---- verification/slsup_top_tb.sv ----
// self-checking bench of the supervisor channel
`timescale 1ns/1ns
`default_nettype none
module slsup_top_tb;
	logic        mclk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic        sample_tick = 1'h0, pready, pslverr, cond_out, warn_out, fault_out, irq;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, sig_in = 32'h0, prdata;
	logic [15:0] event_code;
	logic [32:0] q[$], e;
	int          n_mismatch = 0, num_checks = 0, i, j;
	logic [3:0]  md[6] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h0};
	logic [5:0]  ev[6] = '{6'h36, 6'h1A, 6'h27, 6'h06, 6'h06, 6'h00};
	int          sv[6][6] = '{
		'{32'sh834, 32'sh835, 32'sh7D0, 32'sh5DC, 32'sh383, 32'sh3E8},
		'{-32'sh834, -32'sh835, -32'sh5DC, 32'sh0, -32'sh3E8, -32'sh5DC},
		'{32'sh835, 32'sh5DC, 32'sh384, 32'sh383, 32'sh5DC, 32'sh835},
		'{32'sh5DC, 32'sh320, 32'sh3E8, 32'sh4B0, 32'sh3E8, 32'sh320},
		'{32'sh5DC, 32'sh898, 32'sh7D0, 32'sh708, 32'sh7D0, 32'sh898},
		'{6{32'sh0}}};
	slsup_top dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_tick(sample_tick), .sig_in(sig_in), .cond_out(cond_out), .warn_out(warn_out),
		.fault_out(fault_out), .event_code(event_code), .irq(irq));
	always #5 mclk = ~mclk;
	////////////////////////////////////////////////////////////////////////////////
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
		int k;
		q.push_back(x);
		psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge mclk) penable <= 1'h1;
		k = 0;
		@(posedge mclk);
		while (pready !== 1'h1 && k < 20) begin
			k++;
			@(posedge mclk);
		end
		if (k == 20) begin
			n_mismatch++;
			$display("ERROR %0t: no bus answer", $time);
			end_sim;
		end
		psel    <= 1'h0;
		penable <= 1'h0;
		@(posedge mclk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d); bus(1'h1, a, d, 33'h0); endtask
	task rd(input logic [7:0] a, input logic [31:0] x); bus(1'h0, a, 32'h0, {1'h0, x}); endtask
	task tick(input logic [31:0] v);
		sig_in <= v; sample_tick <= 1'h1;
		@(posedge mclk) sample_tick <= 1'h0;
		@(posedge mclk);
	endtask
	task pin(input logic x);
		num_checks++;
		if (irq !== x) begin
			n_mismatch++;
			$display("ERROR %0t: irq %b expected %b", $time, irq, x);
		end
	endtask
	always @(posedge mclk) begin
		if (psel && penable && pready === 1'h1) begin
			e = q.pop_front();
			num_checks++;
			if (pslverr !== e[32] || (!pwrite && prdata !== e[31:0])) begin
				n_mismatch++;
				$display("ERROR %0t: at %h got %h expected %h", $time, paddr, prdata, e[31:0]);
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(62153));
		repeat (3) @(posedge mclk);
		rst <= 1'h0;
		rd(slsup_pkg::OFS_CTRL, 32'h0);
		rd(slsup_pkg::OFS_LOW, 32'h0);
		wr(slsup_pkg::OFS_HYST, 32'h7FFFFFFF);
		rd(slsup_pkg::OFS_HYST, 32'h00989680);
		wr(slsup_pkg::OFS_LOW, 32'h80000000);
		rd(slsup_pkg::OFS_LOW, 32'h80000030);
		bus(1'h0, 8'h20, 32'h0, {1'h1, 32'h0});
		bus(1'h1, 8'h20, 32'h1, {1'h1, 32'h0});
		$display("register test done");
		wr(slsup_pkg::OFS_LOW, 32'h3E8);
		wr(slsup_pkg::OFS_HIGH, 32'h7D0);
		wr(slsup_pkg::OFS_HYST, 32'hC8);
		for (i = 0; i < 6; i++) begin
			wr(slsup_pkg::OFS_CTRL, {28'h0, md[i]});
			rd(slsup_pkg::OFS_STATUS, 32'h0);
			for (j = 0; j < 6; j++) begin
				tick(md[i] == 4'h0 ? $urandom : sv[i][j]);
				rd(slsup_pkg::OFS_STATUS, {31'h0, ev[i][j]});
			end
		end
		$display("mode test done");
		wr(slsup_pkg::OFS_CTRL, 32'h105);
		tick(32'h835);
		rd(slsup_pkg::OFS_STATUS, 32'h3);
		rd(slsup_pkg::OFS_EVCODE, 32'hA8B1);
		rd(slsup_pkg::OFS_IRQ_ST, 32'h1);
		pin(1'h0);
		wr(slsup_pkg::OFS_IRQ_MSK, 32'h3);
		pin(1'h1);
		wr(slsup_pkg::OFS_IRQ_ST, 32'h3);
		pin(1'h0);
		tick(32'h5DC);
		rd(slsup_pkg::OFS_EVCODE, 32'h0);
		wr(slsup_pkg::OFS_CTRL, 32'h205);
		tick(32'h835);
		rd(slsup_pkg::OFS_STATUS, 32'h5);
		rd(slsup_pkg::OFS_IRQ_ST, 32'h2);
		pin(1'h1);
		tick(32'h5DC);
		rd(slsup_pkg::OFS_STATUS, 32'h4);
		rd(slsup_pkg::OFS_EVCODE, 32'h80B1);
		wr(slsup_pkg::OFS_STATUS, 32'h4);
		wr(slsup_pkg::OFS_IRQ_ST, 32'h3);
		rd(slsup_pkg::OFS_EVCODE, 32'h0);
		wr(slsup_pkg::OFS_CTRL, 32'h5);
		tick(32'h835);
		rd(slsup_pkg::OFS_STATUS, 32'h1);
		rd(slsup_pkg::OFS_IRQ_ST, 32'h0);
		pin(1'h0);
		wr(slsup_pkg::OFS_CTRL, 32'h105);
		rd(slsup_pkg::OFS_STATUS, 32'h3);
		rst <= 1'h1;
		@(posedge mclk) rst <= 1'h0;
		rd(slsup_pkg::OFS_STATUS, 32'h0);
		rd(slsup_pkg::OFS_HIGH, 32'h0);
		$display("action and reset test done");
		end_sim;
	end
endmodule // slsup_top_tb
bind slsup_top slsup_properties chk (.mclk, .rst, .psel, .penable, .pwrite, .sample_tick,
	.cond_out, .warn_out, .fault_out, .event_code);
`default_nettype wire
